// ==== bb_mau_pkg.sv ====
/*
 * Shared constants for the broadband attachment unit collision core.
 * Assumes a 20 MHz system clock; bit-level strobes come from the DTE side
 * and the demodulator as one-cycle qualifiers.
 */
`default_nettype none
package bb_mau_pkg;
    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int JABBER_MAX_MS = 150;
    localparam int JABBER_MIN_MS = 20;
    localparam int JABBER_CYC = (CLK_HZ / 1000) * JABBER_MAX_MS;
    localparam int UMD_TIMER_BITS = 64;
    // ----------------------------------------------------------------
    // scrambler and frame layout
    // ----------------------------------------------------------------
    localparam int SCR_LEN = 23;
    localparam int SCR_TAP_A = 17;
    localparam int SCR_TAP_B = 22;
    localparam logic [22:0] SCR_RESET = 23'h000001;
    localparam int CMP_BITS = 8 * (8 + 6 + 6);
    localparam int POST_BITS = 23;
    localparam logic [22:0] POST_PATTERN = 23'h7ffffe;
    localparam logic [7:0] UMD_PATTERN = 8'h5f;
    localparam int CMP_FIFO_DEPTH = 2;
endpackage
`default_nettype wire

// ==== bit_buffer.sv ====
/*
 * Two-entry bit buffer with valid and ready on both sides.
 * Assumes a single clock and synchronous use of all handshakes.
 */
`default_nettype none
module bit_buffer #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_n,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    initial begin
        if (DEPTH != 2) $error("bit_buffer supports depth 2 only");
    end
    logic [WIDTH-1:0] mem [2];
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o = mem[rd_ptr];
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge clk_i) begin
        if (push) mem[wr_ptr] <= in_data_i;
    end
endmodule
`default_nettype wire

// ==== bb_mau_core.sv ====
/*
 * Digital core of a broadband attachment unit: scrambles DTE bits,
 * appends a postamble once the DTE goes inactive, compares echoed bits,
 * drives collision enforcement, signal-quality-error and jabber guard.
 * Assumes NRZ bits with strobes from the AUI decoder and demodulator,
 * all synchronous to sys_clk_i.
 */
`default_nettype none
module bb_mau_core #(
    parameter int JABBER_CYCLES = bb_mau_pkg::JABBER_CYC,
    parameter int UMD_TIMER = bb_mau_pkg::UMD_TIMER_BITS
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic dte_active_i,
    input wire logic dte_bit_stb_i,
    input wire logic dte_bit_i,
    input wire logic rx_present_i,
    input wire logic rx_bit_stb_i,
    input wire logic rx_bit_i,
    input wire logic ce_detect_i,
    input wire logic dte_ready_i,
    output logic tx_data_en_o,
    output logic tx_bit_o,
    output logic tx_ce_en_o,
    output logic dte_rx_valid_o,
    output logic dte_rx_bit_o,
    output logic sqe_o,
    output logic jabber_o
);
    initial begin
        if (JABBER_CYCLES < 2) $error("jabber count too small");
        if (UMD_TIMER < 8) $error("delimiter timer too small");
    end
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end
    // ----------------------------------------------------------------
    // transmit state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {TX_IDLE, TX_DATA, TX_POST, TX_COLL, TX_JAB} tx_state_t;
    tx_state_t tx_state;
    tx_state_t next_tx_state;
    logic [22:0] scr;
    logic [4:0] post_cnt;
    logic [31:0] jab_cnt;
    logic [8:0] tx_cmp_cnt;
    logic tx_umd_seen;
    logic [7:0] tx_shift;
    logic [7:0] rx_shift;
    logic rx_umd_seen;
    logic [8:0] rx_cmp_cnt;
    logic [15:0] umd_timer;
    logic collision;
    logic cmp_pop;
    logic cmp_valid;
    logic cmp_bit;
    logic cmp_ready;
    logic rx_ready;
    logic rxq_valid;
    logic rxq_bit;
    wire scr_fb = scr[bb_mau_pkg::SCR_TAP_A] ^ scr[bb_mau_pkg::SCR_TAP_B];
    wire scr_bit = dte_bit_i ^ scr_fb;
    wire tx_step = dte_bit_stb_i && (tx_state == TX_DATA);
    wire tx_cmp_win = tx_umd_seen && (tx_cmp_cnt < 9'(bb_mau_pkg::CMP_BITS));
    wire jab_hit = (jab_cnt >= 32'(JABBER_CYCLES));
    wire post_done = (post_cnt == 5'(bb_mau_pkg::POST_BITS - 1));
    // receive compare window after receive delimiter
    wire rx_cmp_win = rx_umd_seen && (rx_cmp_cnt < 9'(bb_mau_pkg::CMP_BITS));
    // echo checked against buffered sent bit
    assign cmp_pop = rx_bit_stb_i && rx_cmp_win && cmp_valid;
    // mismatch, or an echo with no sent bit to match while in TX_DATA, is a collision
    wire cmp_short = rx_bit_stb_i && rx_cmp_win && !cmp_valid && (tx_state == TX_DATA);
    wire mismatch = (cmp_pop && (cmp_bit != rx_bit_i)) || cmp_short;
    // leftovers of a cut frame drain while idle so the next compare stays aligned
    wire cmp_drain = cmp_pop || (tx_state == TX_IDLE);
    wire umd_expired = rx_present_i && !rx_umd_seen && (umd_timer >= 16'(UMD_TIMER));
    wire coll_event = mismatch || umd_expired || ce_detect_i;
    always_comb begin
        next_tx_state = tx_state;
        case (tx_state)
            TX_IDLE: begin
                if (dte_active_i) next_tx_state = TX_DATA;
            end
            TX_DATA: begin
                if (jab_hit) next_tx_state = TX_JAB;
                else if (coll_event) next_tx_state = TX_COLL;
                else if (!dte_active_i) next_tx_state = TX_POST;
            end
            TX_POST: begin
                if (post_done) next_tx_state = TX_IDLE;
            end
            TX_COLL: begin
                if (jab_hit) next_tx_state = TX_JAB;
                else if (!dte_active_i) next_tx_state = TX_IDLE;
            end
            TX_JAB: begin
                if (!dte_active_i) next_tx_state = TX_IDLE;
            end
            default: next_tx_state = TX_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= TX_IDLE;
            scr <= bb_mau_pkg::SCR_RESET;
            post_cnt <= 5'h00;
            jab_cnt <= 32'h0;
            tx_cmp_cnt <= 9'h000;
            tx_umd_seen <= 1'b0;
            tx_shift <= 8'h00;
        end else begin
            tx_state <= next_tx_state;
            // seed carries over: scrambler never reloads between packets
            if (tx_step) scr <= {scr[21:0], scr_bit};
            post_cnt <= (tx_state == TX_POST) ? post_cnt + 5'h01 : 5'h00;
            // jabber timer on any transmit activity
            jab_cnt <= (tx_state == TX_IDLE) ? 32'h0 : (jab_hit ? jab_cnt : jab_cnt + 32'h1);
            if (tx_state == TX_IDLE) begin
                tx_umd_seen <= 1'b0;
                tx_cmp_cnt <= 9'h000;
                tx_shift <= 8'h00;
            end else if (tx_step) begin
                tx_shift <= {tx_shift[6:0], dte_bit_i};
                if ({tx_shift[6:0], dte_bit_i} == bb_mau_pkg::UMD_PATTERN) tx_umd_seen <= 1'b1;
                if (tx_cmp_win) tx_cmp_cnt <= tx_cmp_cnt + 9'h001;
            end
        end
    end
    // ----------------------------------------------------------------
    // sent-bit buffer for the compare; echo latency keeps it at two bits or fewer
    // ----------------------------------------------------------------
    bit_buffer #(.WIDTH(1), .DEPTH(bb_mau_pkg::CMP_FIFO_DEPTH)) cmp_buf (
        .clk_i(sys_clk_i),
        .rst_n(rst_n),
        .in_valid_i(tx_step && tx_cmp_win),
        .in_ready_o(cmp_ready),
        .in_data_i(scr_bit),
        .out_valid_o(cmp_valid),
        .out_ready_i(cmp_drain),
        .out_data_o(cmp_bit)
    );
    // received bits wait here while the dte stalls
    wire rxq_pop = rxq_valid && dte_ready_i;
    bit_buffer #(.WIDTH(1), .DEPTH(2)) rx_buf (
        .clk_i(sys_clk_i),
        .rst_n(rst_n),
        .in_valid_i(rx_present_i && rx_bit_stb_i),
        .in_ready_o(rx_ready),
        .in_data_i(rx_bit_i),
        .out_valid_o(rxq_valid),
        .out_ready_i(rxq_pop),
        .out_data_o(rxq_bit)
    );
    // ----------------------------------------------------------------
    // receive side
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_shift <= 8'h00;
            rx_umd_seen <= 1'b0;
            rx_cmp_cnt <= 9'h000;
            umd_timer <= 16'h0000;
            collision <= 1'b0;
        end else begin
            if (!rx_present_i) begin
                rx_shift <= 8'h00;
                rx_umd_seen <= 1'b0;
                rx_cmp_cnt <= 9'h000;
                umd_timer <= 16'h0000;
            end else if (rx_bit_stb_i) begin
                rx_shift <= {rx_shift[6:0], rx_bit_i};
                if ({rx_shift[6:0], rx_bit_i} == bb_mau_pkg::UMD_PATTERN) rx_umd_seen <= 1'b1;
                if (rx_cmp_win) rx_cmp_cnt <= rx_cmp_cnt + 9'h001;
                if (!rx_umd_seen && !umd_expired) umd_timer <= umd_timer + 16'h0001;
            end
            // collision holds while either band is live; new event wins
            if (coll_event) collision <= 1'b1;
            else if (!rx_present_i && !ce_detect_i) collision <= 1'b0;
        end
    end
    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    wire sending = (tx_state == TX_DATA) || (tx_state == TX_POST);
    wire post_bit = bb_mau_pkg::POST_PATTERN[post_cnt];
    // preamble and delimiter leave unscrambled so the far end can find them
    wire next_tx_bit = (tx_state == TX_POST) ? post_bit : (tx_umd_seen ? scr_bit : dte_bit_i);
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_data_en_o <= 1'b0;
            tx_bit_o <= 1'b0;
            tx_ce_en_o <= 1'b0;
            dte_rx_valid_o <= 1'b0;
            dte_rx_bit_o <= 1'b0;
            sqe_o <= 1'b0;
            jabber_o <= 1'b0;
        end else begin
            // data band off, enforcement band on
            tx_data_en_o <= sending && !collision;
            tx_ce_en_o <= (tx_state == TX_COLL);
            // DTE bits onto the medium
            // line bit holds between strobes so the echo samples a settled value
            if ((tx_state == TX_POST) || tx_step) tx_bit_o <= next_tx_bit;
            dte_rx_valid_o <= rxq_pop;
            dte_rx_bit_o <= rxq_bit;
            sqe_o <= collision || ce_detect_i || (tx_state == TX_JAB);
            jabber_o <= (tx_state == TX_JAB);
        end
    end
    wire unused_ok = cmp_ready & rx_ready;
endmodule
`default_nettype wire

// ==== mau_checker_assertions.sv ====
/*
 * Port-level checker for the broadband attachment unit core.
 * Assumes it is bound into bb_mau_core and sees its ports only.
 */
`default_nettype none
module mau_checker #(
    parameter int JABBER_CYCLES = bb_mau_pkg::JABBER_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic dte_active_i,
    input wire logic rx_present_i,
    input wire logic ce_detect_i,
    input wire logic tx_data_en_o,
    input wire logic tx_ce_en_o,
    input wire logic sqe_o,
    input wire logic jabber_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // run length of the current dte burst, for the jabber lower bound
    int act_cnt;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_cnt <= 0;
        end else begin
            act_cnt <= dte_active_i ? act_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_ce_sqe; ce_detect_i |-> ##[1:3] sqe_o; endproperty
    a_ce_sqe: assert property (p_ce_sqe) else $error("no sqe on ce energy");
    property p_ce_hold; sqe_o && ce_detect_i |=> sqe_o; endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("sqe dropped under energy");
    property p_sqe_clear;
        (!rx_present_i && !ce_detect_i && !jabber_o) [*4] |=> !sqe_o;
    endproperty
    a_sqe_clear: assert property (p_sqe_clear) else $error("sqe stuck on quiet line");
    property p_ce_excl; tx_ce_en_o |-> !tx_data_en_o; endproperty
    a_ce_excl: assert property (p_ce_excl) else $error("both bands driven");
    property p_ce_end; !dte_active_i [*3] |=> !tx_ce_en_o; endproperty
    a_ce_end: assert property (p_ce_end) else $error("ce band after dte idle");
    property p_start;
        $rose(dte_active_i) && !sqe_o && !jabber_o && !rx_present_i |-> ##[1:3] tx_data_en_o;
    endproperty
    a_start: assert property (p_start) else $error("data band not started");
    property p_jab_sqe; jabber_o |-> ##[0:2] sqe_o; endproperty
    a_jab_sqe: assert property (p_jab_sqe) else $error("no sqe under jabber");
    property p_jab_off; jabber_o ##1 jabber_o |-> !tx_data_en_o; endproperty
    a_jab_off: assert property (p_jab_off) else $error("output not inhibited");
    property p_jab_min; $rose(jabber_o) |-> act_cnt > JABBER_CYCLES * 2 / 15; endproperty
    a_jab_min: assert property (p_jab_min) else $error("jabber on short burst");
endmodule
bind bb_mau_core mau_checker #(.JABBER_CYCLES(JABBER_CYCLES)) u_chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .dte_active_i(dte_active_i),
    .rx_present_i(rx_present_i), .ce_detect_i(ce_detect_i), .tx_data_en_o(tx_data_en_o),
    .tx_ce_en_o(tx_ce_en_o), .sqe_o(sqe_o), .jabber_o(jabber_o));
`default_nettype wire

// ==== medium_model.sv ====
/*
 * Shared medium: echoes the data band three cycles after each dte strobe,
 * adds bits injected by the bench and enforcement energy.
 * Assumes tx_bit_i settles one cycle after its dte strobe.
 */
`default_nettype none
module medium_model (
    input wire logic clk_i,
    input wire logic tx_stb_i,
    input wire logic tx_en_i,
    input wire logic tx_bit_i,
    input wire logic ce_en_i,
    input wire logic corrupt_i,
    input wire logic inj_present_i,
    input wire logic inj_stb_i,
    input wire logic inj_bit_i,
    input wire logic ce_on_i,
    output logic present_o,
    output logic stb_o,
    output logic bit_o,
    output logic ce_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] dly = 2'h0;
    logic echo_stb = 1'b0;
    logic echo_bit = 1'b0;
    logic junk = 1'b0;
    // echo of own data; corruption only when commanded
    always @(posedge clk_i) begin
        dly <= {dly[0], tx_stb_i};
        echo_stb <= dly[1];
        junk <= ~junk;
        if (dly[1]) begin
            echo_bit <= tx_bit_i ^ corrupt_i;
        end
    end
    // idle bit line toggles so a stale value never passes
    assign present_o = tx_en_i | inj_present_i;
    assign stb_o = echo_stb | inj_stb_i;
    assign bit_o = echo_stb ? echo_bit : (inj_stb_i ? inj_bit_i : junk);
    assign ce_o = ce_en_i | ce_on_i;
endmodule
`default_nettype wire

// ==== testbench.sv ====
/*
 * Self-checking bench for bb_mau_core with a medium model.
 * Assumes a shortened jabber count of 1000 cycles.
 */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i, rst_n_i, dte_active_i, dte_bit_stb_i, dte_bit_i, dte_ready_i;
    logic corrupt, inj_present, inj_stb, inj_bit, ce_on, track;
    logic rx_present_i, rx_bit_stb_i, rx_bit_i, ce_detect_i;
    logic tx_data_en_o, tx_bit_o, tx_ce_en_o, dte_rx_valid_o, dte_rx_bit_o, sqe_o, jabber_o;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 76368;
    int q[$];
    // scrambler model, stepped on every bit the dte sends
    logic [22:0] scr_m = bb_mau_pkg::SCR_RESET;
    logic scr_chk = 1'b0;
    bb_mau_core #(.JABBER_CYCLES(1000)) DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .dte_active_i(dte_active_i), .dte_bit_stb_i(dte_bit_stb_i), .dte_bit_i(dte_bit_i),
        .rx_present_i(rx_present_i), .rx_bit_stb_i(rx_bit_stb_i), .rx_bit_i(rx_bit_i),
        .ce_detect_i(ce_detect_i), .dte_ready_i(dte_ready_i), .tx_data_en_o(tx_data_en_o),
        .tx_bit_o(tx_bit_o), .tx_ce_en_o(tx_ce_en_o), .dte_rx_valid_o(dte_rx_valid_o),
        .dte_rx_bit_o(dte_rx_bit_o), .sqe_o(sqe_o), .jabber_o(jabber_o));
    medium_model u_med (.clk_i(sys_clk_i), .tx_stb_i(dte_bit_stb_i), .tx_en_i(tx_data_en_o),
        .tx_bit_i(tx_bit_o), .ce_en_i(tx_ce_en_o), .corrupt_i(corrupt),
        .inj_present_i(inj_present), .inj_stb_i(inj_stb), .inj_bit_i(inj_bit), .ce_on_i(ce_on),
        .present_o(rx_present_i), .stb_o(rx_bit_stb_i), .bit_o(rx_bit_i), .ce_o(ce_detect_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic send_bit(input logic b, input logic scram);
        logic e;
        e = b ^ scr_m[bb_mau_pkg::SCR_TAP_A] ^ scr_m[bb_mau_pkg::SCR_TAP_B];
        scr_m = {scr_m[21:0], e};
        @(negedge sys_clk_i) {dte_bit_stb_i, dte_bit_i} = {1'b1, b};
        @(negedge sys_clk_i) dte_bit_stb_i = 1'b0;
        if (scr_chk) check(tx_bit_o, scram ? e : b, "line bit");
    endtask
    task automatic inj_rx(input logic b);
        @(negedge sys_clk_i) {inj_stb, inj_bit} = {1'b1, b};
        if (track) q.push_back(int'(b));
        @(negedge sys_clk_i) inj_stb = 1'b0;
        repeat (2) @(negedge sys_clk_i);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // stalls from the dte side; the two-entry buffer must absorb them
    // outputs are looked at half a cycle after they launch
    always @(negedge sys_clk_i) begin
        dte_ready_i = ($random(seed) & 3) != 0;
        if (track && dte_rx_valid_o === 1'b1) begin
            check(32'(dte_rx_bit_o), q.size() > 0 ? q.pop_front() : 2, "rx bit");
        end
    end
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            stop_test();
        end
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        {dte_active_i, dte_bit_stb_i, dte_bit_i, dte_ready_i, corrupt} = 5'h00;
        {inj_present, inj_stb, inj_bit, ce_on, track} = 5'h00;
        rst_n_i = 1'b0;
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i) rst_n_i = 1'b1;
        wait_n(3);
        check({tx_data_en_o, tx_ce_en_o, sqe_o, jabber_o}, 0, "reset outputs");
        track = 1'b1;
        inj_present = 1'b1;
        repeat (40) inj_rx(1'($random(seed)));
        wait_n(10);
        {inj_present, track} = 2'h0;
        check(q.size(), 0, "bits lost to dte");
        // no delimiter on a present carrier
        inj_present = 1'b1;
        repeat (70) inj_rx(1'b0);
        check(sqe_o, 1, "delimiter timeout");
        inj_present = 1'b0;
        wait_n(6);
        check(sqe_o, 0, "sqe after quiet");
        for (int c = 0; c < 2; c++) begin
            scr_chk = !c[0];
            @(negedge sys_clk_i) dte_active_i = 1'b1;
            // short preamble: the delimiter must land before the receive timer ends
            for (int i = 0; i < 28; i++) begin
                send_bit(i < 20 ? i[0] : 1'(bb_mau_pkg::UMD_PATTERN >> (27 - i)), 1'b0);
            end
            for (int i = 0; i < 200; i++) begin
                if (i == 60) corrupt = c[0];
                send_bit(1'($random(seed)), 1'b1);
            end
            check(sqe_o, c, "echo compare");
            check({tx_data_en_o, tx_ce_en_o}, c ? 2'h1 : 2'h2, "band select");
            @(negedge sys_clk_i) {dte_active_i, corrupt} = 2'h0;
            wait_n(1);
            // postamble goes out lsb first, one bit per cycle
            for (int k = 0; k < bb_mau_pkg::POST_BITS; k++) begin
                wait_n(1);
                if (!c) check(tx_bit_o, 32'(bb_mau_pkg::POST_PATTERN[k]), "postamble bit");
                if (k == 3) check(tx_data_en_o, !c, "postamble");
            end
            wait_n(40);
            check({tx_data_en_o, tx_ce_en_o, sqe_o}, 0, "frame end");
        end
        ce_on = 1'b1;
        wait_n(5);
        check(sqe_o, 1, "enforcement energy");
        ce_on = 1'b0;
        wait_n(5);
        check(sqe_o, 0, "energy gone");
        dte_active_i = 1'b1;
        wait_n(120);
        check(jabber_o, 0, "short burst");
        wait_n(900);
        check({jabber_o, sqe_o, tx_data_en_o}, 3'h6, "jabber guard");
        stop_test();
    end
endmodule
`default_nettype wire
